// ==== verilog/rxcfg_bank.sv ====
// Receive-port alias slots five to seven and port input configuration bank
`timescale 1ns/1ps
`include "rxcfg_defines.svh"
// Operation
// - Alias bits 7:1 reset zero; matching local address is remapped to remote target.
// - A zero alias disables the slot; it never matches.
// - Auto-ack bit 0 acknowledges writes locally regardless of lock or remote ack.
// - Host selects the port first; accesses go to that port's register copy.
// - Bit 7 drops packets until frame start with frame count one.
// - Bit 6, reset one, drops packets until any frame start.
// - Frame-start waits and checksum control are ignored in RAW modes.
// - Bit 5, reset one, forwards checksum errored packets; zero drops them.
// - Bit 4, reset one, forwards header ECC errored packets; zero drops them.
// - RAW mode bit 3 drops the short first line; zero forwards it.
// - CSI-2 mode bit 3 forwards length errored packets; zero drops them.
// - Mode bits 1:0 from straps: CSI-2, RAW12 LF, RAW12 HF, RAW10.
module rxcfg_bank
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Strap pins, caught after reset release
  input wire logic [2:0] strap_i,
  // Register access port from the I2C target
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Local I2C transaction to decode
  input rxcfg_pkg::rxcfg_i2c_req_t i2c_req_i,
  output rxcfg_pkg::rxcfg_route_t route_o,
  output logic [6:0] remote_addr_o,
  // Remote target addresses per port and slot
  input wire logic [`RXCFG_NUM_PORTS*`RXCFG_NUM_SLOTS*7-1:0] remote_id_i,
  // CSI-2 packets per port
  input rxcfg_pkg::rxcfg_csi_pkt_t [`RXCFG_NUM_PORTS-1:0] pkt_i,
  output logic [`RXCFG_NUM_PORTS-1:0] pkt_pass_o,
  output logic [`RXCFG_NUM_PORTS-1:0] pkt_waiting_o,
  // RAW first line handling per port
  input wire logic [`RXCFG_NUM_PORTS-1:0] short_line_i,
  output logic [`RXCFG_NUM_PORTS-1:0] drop_line_o
);
  import rxcfg_pkg::*;
  localparam int NP = `RXCFG_NUM_PORTS;
  localparam int NS = `RXCFG_NUM_SLOTS;
  rxcfg_alias_t alias_ff [NP][NS];
  rxcfg_alias_t nxt_alias [NP][NS];
  rxcfg_port_cfg_t cfg_ff [NP];
  rxcfg_port_cfg_t nxt_cfg [NP];
  logic [1:0] sel_ff;
  logic [1:0] nxt_sel;
  logic strap_done_ff;
  logic nxt_strap_done;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  rxcfg_route_t route_ff;
  rxcfg_route_t nxt_route;
  logic [6:0] raddr_ff;
  logic [6:0] nxt_raddr;

  // Address and mode decode helpers
  function automatic logic [1:0] slot_of(input logic [7:0] addr);
    slot_of = 2'(addr - `RXCFG_OFF_ALIAS_FIVE);
  endfunction

  function automatic logic is_alias_off(input logic [7:0] addr);
    is_alias_off = (addr >= `RXCFG_OFF_ALIAS_FIVE) && (addr <= `RXCFG_OFF_ALIAS_SEVEN);
  endfunction

  function automatic logic is_sel_off(input logic [7:0] addr);
    is_sel_off = (addr == `RXCFG_OFF_PORT_SEL);
  endfunction

  function automatic logic is_cfg_off(input logic [7:0] addr);
    is_cfg_off = (addr == `RXCFG_OFF_PORT_CFG);
  endfunction

  function automatic logic is_raw_mode(input rxcfg_mode_t mode);
    is_raw_mode = (mode != RXCFG_MODE_CSI2);
  endfunction

  // Register writes and strap capture
  always_comb
  begin
    nxt_sel = sel_ff;
    nxt_strap_done = 1'b1;
    for (int p = 0; p < NP; p++)
    begin
      nxt_cfg[p] = cfg_ff[p];
      for (int s = 0; s < NS; s++)
      begin
        nxt_alias[p][s] = alias_ff[p][s];
      end
      if (!strap_done_ff)
      begin
        nxt_cfg[p].strap_rsvd = strap_i[`RXCFG_BIT_STRAP_RSVD];
        nxt_cfg[p].link_input_mode = rxcfg_mode_t'(strap_i[`RXCFG_MODE_MSB:0]);
      end
    end
    if (reg_wr_i)
    begin
      if (is_sel_off(reg_addr_i))
      begin
        nxt_sel = reg_wdata_i[1:0];
      end
      else if (is_alias_off(reg_addr_i))
      begin
        nxt_alias[sel_ff][slot_of(reg_addr_i)] = rxcfg_alias_t'(reg_wdata_i);
      end
      else if (is_cfg_off(reg_addr_i))
      begin
        nxt_cfg[sel_ff] = rxcfg_port_cfg_t'(reg_wdata_i);
      end
    end
  end

  // Register reads, selected port copy
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i)
    begin
      if (is_sel_off(reg_addr_i))
      begin
        nxt_rdata = {6'h00, sel_ff};
      end
      else if (is_alias_off(reg_addr_i))
      begin
        nxt_rdata = alias_ff[sel_ff][slot_of(reg_addr_i)];
      end
      else if (is_cfg_off(reg_addr_i))
      begin
        nxt_rdata = cfg_ff[sel_ff];
      end
      else
      begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // Alias decoder across all ports and slots
  always_comb
  begin
    nxt_route = '0;
    nxt_raddr = 7'h00;
    if (i2c_req_i.valid)
    begin
      for (int p = 0; p < NP; p++)
      begin
        for (int s = 0; s < NS; s++)
        begin
          if (!nxt_route.hit && alias_ff[p][s].alias_addr != 7'h00
              && alias_ff[p][s].alias_addr == i2c_req_i.addr)
          begin
            nxt_route.hit = 1'b1;
            nxt_route.port = 2'(p);
            nxt_route.slot = 2'(s);
            nxt_route.auto_ack = alias_ff[p][s].auto_ack && i2c_req_i.is_write;
            nxt_raddr = remote_id_i[(p*NS+s)*7 +: 7];
          end
        end
      end
    end
  end

  // State registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      rdata_ff <= 8'h00;
      route_ff <= '0;
      raddr_ff <= 7'h00;
      for (int p = 0; p < NP; p++)
      begin
        cfg_ff[p] <= rxcfg_port_cfg_t'({`RXCFG_CFG_RESET_HI, 2'h0});
        for (int s = 0; s < NS; s++)
        begin
          alias_ff[p][s] <= rxcfg_alias_t'(`RXCFG_ALIAS_RESET);
        end
      end
    end
    else
    begin
      sel_ff <= nxt_sel;
      strap_done_ff <= nxt_strap_done;
      rdata_ff <= nxt_rdata;
      route_ff <= nxt_route;
      raddr_ff <= nxt_raddr;
      for (int p = 0; p < NP; p++)
      begin
        cfg_ff[p] <= nxt_cfg[p];
        for (int s = 0; s < NS; s++)
        begin
          alias_ff[p][s] <= nxt_alias[p][s];
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = rdata_ff;
  assign route_o = route_ff;
  assign remote_addr_o = raddr_ff;

  // Per-port packet gates and RAW first line handling
  for (genvar g = 0; g < NP; g++)
  begin : g_port
    rxcfg_pkt_gate u_gate
    (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .cfg_i(cfg_ff[g]),
      .pkt_i(pkt_i[g]),
      .pass_o(pkt_pass_o[g]),
      .waiting_o(pkt_waiting_o[g])
    );
    assign drop_line_o[g] = short_line_i[g] && cfg_ff[g].drop_short_first_line
                            && is_raw_mode(cfg_ff[g].link_input_mode);
  end
endmodule

// ==== verilog/rxcfg_defines.svh ====
// Register offsets, field positions and reset values for the receive-port configuration bank
`ifndef RXCFG_DEFINES_SVH
`define RXCFG_DEFINES_SVH
`define RXCFG_NUM_PORTS 4
`define RXCFG_NUM_SLOTS 3
`define RXCFG_OFF_PORT_SEL 8'h4C
`define RXCFG_OFF_ALIAS_FIVE 8'h6A
`define RXCFG_OFF_ALIAS_SIX 8'h6B
`define RXCFG_OFF_ALIAS_SEVEN 8'h6C
`define RXCFG_OFF_PORT_CFG 8'h6D
`define RXCFG_ALIAS_RESET 8'h00
`define RXCFG_CFG_RESET_HI 6'h1E
`define RXCFG_BIT_WAIT_FC1 7
`define RXCFG_BIT_WAIT_FS 6
`define RXCFG_BIT_PASS_CKSUM 5
`define RXCFG_BIT_PASS_ECC 4
`define RXCFG_BIT_LINE_LEN 3
`define RXCFG_BIT_STRAP_RSVD 2
`define RXCFG_MODE_MSB 1
`define RXCFG_FRAME_COUNT_ONE 16'h0001
`endif

// ==== verilog/rxcfg_pkg.sv ====
// Types for the receive-port configuration bank
package rxcfg_pkg;
  typedef enum logic [1:0] {
    RXCFG_MODE_CSI2 = 2'h0,
    RXCFG_MODE_RAW12_LF = 2'h1,
    RXCFG_MODE_RAW12_HF = 2'h2,
    RXCFG_MODE_RAW10 = 2'h3
  } rxcfg_mode_t;
  typedef struct packed {
    logic [6:0] alias_addr;
    logic auto_ack;
  } rxcfg_alias_t;
  typedef struct packed {
    logic wait_first_frame_count_one;
    logic wait_any_frame_begin;
    logic pass_checksum_errored;
    logic pass_header_errored;
    logic drop_short_first_line;
    logic strap_rsvd;
    rxcfg_mode_t link_input_mode;
  } rxcfg_port_cfg_t;
  typedef struct packed {
    logic valid;
    logic frame_start;
    logic [15:0] frame_count;
    logic cksum_err;
    logic ecc_err;
    logic len_err;
  } rxcfg_csi_pkt_t;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic is_write;
  } rxcfg_i2c_req_t;
  typedef struct packed {
    logic hit;
    logic [1:0] port;
    logic [1:0] slot;
    logic auto_ack;
  } rxcfg_route_t;
endpackage

// ==== verilog/rxcfg_pkt_gate.sv ====
// Per-port CSI-2 packet gate applying frame-start wait and error forwarding
`timescale 1ns/1ps
`include "rxcfg_defines.svh"
module rxcfg_pkt_gate
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Configuration
  input rxcfg_pkg::rxcfg_port_cfg_t cfg_i,
  // Incoming packet
  input rxcfg_pkg::rxcfg_csi_pkt_t pkt_i,
  // Verdict
  output logic pass_o,
  output logic waiting_o
);
  import rxcfg_pkg::*;
  logic seen_fs_ff;
  logic nxt_seen_fs;
  logic seen_fc1_ff;
  logic nxt_seen_fc1;
  logic is_csi;
  logic fs_ok;
  logic err_ok;
  assign is_csi = (cfg_i.link_input_mode == RXCFG_MODE_CSI2);
  always_comb
  begin
    nxt_seen_fs = seen_fs_ff;
    nxt_seen_fc1 = seen_fc1_ff;
    if (pkt_i.valid && pkt_i.frame_start)
    begin
      nxt_seen_fs = 1'b1;
      if (pkt_i.frame_count == `RXCFG_FRAME_COUNT_ONE)
      begin
        nxt_seen_fc1 = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      seen_fs_ff <= 1'b0;
      seen_fc1_ff <= 1'b0;
    end
    else
    begin
      seen_fs_ff <= nxt_seen_fs;
      seen_fc1_ff <= nxt_seen_fc1;
    end
  end
  always_comb
  begin
    fs_ok = 1'b1;
    if (cfg_i.wait_first_frame_count_one && !nxt_seen_fc1)
    begin
      fs_ok = 1'b0;
    end
    if (cfg_i.wait_any_frame_begin && !nxt_seen_fs)
    begin
      fs_ok = 1'b0;
    end
    err_ok = 1'b1;
    if (pkt_i.cksum_err && !cfg_i.pass_checksum_errored)
    begin
      err_ok = 1'b0;
    end
    if (pkt_i.ecc_err && !cfg_i.pass_header_errored)
    begin
      err_ok = 1'b0;
    end
    if (pkt_i.len_err && !cfg_i.drop_short_first_line)
    begin
      err_ok = 1'b0;
    end
  end
  // RAW modes bypass the CSI-2 gating entirely
  assign pass_o = pkt_i.valid && (!is_csi || (fs_ok && err_ok));
  assign waiting_o = is_csi && !fs_ok;
endmodule

// ==== verif/rxcfg_far_model.sv ====
// Far-side model giving the remote target address of every slot
`timescale 1ns/1ps
`include "rxcfg_defines.svh"
module rxcfg_far_model
(
  // Remote target addresses
  output logic [`RXCFG_NUM_PORTS*`RXCFG_NUM_SLOTS*7-1:0] remote_id_o
);
  // Slot at index i answers at 0x40 plus i
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      remote_id_o[i*7 +: 7] = 7'h40 + 7'(i);
  end
endmodule

// ==== verif/rxcfg_props.sv ====
// Assertions on the configuration bank ports
`timescale 1ns/1ps
`include "rxcfg_defines.svh"
module rxcfg_props
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register and decoder
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input rxcfg_pkg::rxcfg_i2c_req_t i2c_req_i,
  input rxcfg_pkg::rxcfg_route_t route_o,
  // Packets and lines
  input rxcfg_pkg::rxcfg_csi_pkt_t [`RXCFG_NUM_PORTS-1:0] pkt_i,
  input wire logic [`RXCFG_NUM_PORTS-1:0] pkt_pass_o,
  input wire logic [`RXCFG_NUM_PORTS-1:0] pkt_waiting_o,
  input wire logic [`RXCFG_NUM_PORTS-1:0] short_line_i,
  input wire logic [`RXCFG_NUM_PORTS-1:0] drop_line_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_pulse;
    !i2c_req_i.valid |=> !route_o.hit;
  endproperty
  a_pulse: assert property (p_pulse) else $error("route without request");
  property p_zero;
    i2c_req_i.valid && i2c_req_i.addr == 7'h00 |=> !route_o.hit;
  endproperty
  a_zero: assert property (p_zero) else $error("zero alias matched");
  property p_ack;
    i2c_req_i.valid && !i2c_req_i.is_write |=> !route_o.auto_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("read acknowledged locally");
  property p_wait;
    pkt_waiting_o[0] && pkt_i[0].valid && !pkt_i[0].frame_start |-> !pkt_pass_o[0];
  endproperty
  a_wait: assert property (p_wait) else $error("packet passed while waiting");
  property p_fc1;
    pkt_i[0].valid && pkt_i[0].frame_start && pkt_i[0].frame_count == 16'h0001
      |=> !pkt_waiting_o[0];
  endproperty
  a_fc1: assert property (p_fc1) else $error("still waiting after count one");
  property p_line;
    (drop_line_o & ~short_line_i) == 4'h0;
  endproperty
  a_line: assert property (p_line) else $error("line dropped without cause");
  property p_unmap;
    reg_rd_i && reg_addr_i == 8'h6E |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  logic fc1_seen_ff;
  logic nxt_fc1_seen;
  always_comb
  begin
    nxt_fc1_seen = fc1_seen_ff;
    if (pkt_i[0].valid && pkt_i[0].frame_start && pkt_i[0].frame_count == 16'h0001)
    begin
      nxt_fc1_seen = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fc1_seen_ff <= 1'b0;
    end
    else
    begin
      fc1_seen_ff <= nxt_fc1_seen;
    end
  end
  property p_sticky;
    fc1_seen_ff |-> !pkt_waiting_o[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("waiting after count one seen");
endmodule

// ==== verif/rxcfg_bank_tb.sv ====
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "rxcfg_defines.svh"
module rxcfg_bank_tb;
  import rxcfg_pkg::*;
  typedef struct packed {logic [7:0] cfg; rxcfg_csi_pkt_t pkt; logic pass;} rxcfg_prow_t;
  typedef struct packed {rxcfg_i2c_req_t req; rxcfg_route_t rt; logic [6:0] ra;} rxcfg_drow_t;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] strap_i = 3'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  rxcfg_i2c_req_t i2c_req_i = '0;
  rxcfg_route_t route_o;
  logic [6:0] remote_addr_o;
  logic [83:0] remote_id_i;
  rxcfg_csi_pkt_t [3:0] pkt_i = '0;
  logic [3:0] pkt_pass_o;
  logic [3:0] pkt_waiting_o;
  logic [3:0] drop_line_o;
  logic [3:0] short_line_i = 4'h0;
  int failures = 0;
  int checks_done = 0;
  rxcfg_prow_t prows [12] = '{
    '{8'h78, 21'h10_0000, 1'b0}, '{8'h78, 21'h18_0028, 1'b1},
    '{8'h78, 21'h10_0004, 1'b1}, '{8'h78, 21'h10_0002, 1'b1},
    '{8'h78, 21'h10_0001, 1'b1}, '{8'h40, 21'h10_0004, 1'b0},
    '{8'h40, 21'h10_0002, 1'b0}, '{8'h40, 21'h10_0001, 1'b0},
    '{8'h40, 21'h10_0000, 1'b1}, '{8'hC0, 21'h10_0000, 1'b0},
    '{8'hC0, 21'h18_0008, 1'b1}, '{8'hC0, 21'h10_0000, 1'b1}};
  rxcfg_drow_t drows [5] = '{
    '{9'h155, 6'h29, 7'h43}, '{9'h154, 6'h28, 7'h43}, '{9'h161, 6'h34, 7'h48},
    '{9'h101, 6'h00, 7'h00}, '{9'h123, 6'h00, 7'h00}};
  rxcfg_bank u_dut (.*);
  rxcfg_far_model u_far (.remote_id_o(remote_id_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(16'(reg_rdata_o), 16'(e));
  endtask
  task automatic pk(input int p, input rxcfg_csi_pkt_t k, input logic e);
    @(posedge sys_clk_i);
    pkt_i[p] <= k;
    #1 chk(16'(pkt_pass_o[p]), 16'(e));
    @(posedge sys_clk_i);
    pkt_i[p] <= '0;
  endtask
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    wr(8'h4C, 8'h00);
    rd(8'h6A, 8'h00);
    rd(8'h6D, 8'h78);
    wr(8'h4C, 8'h01);
    wr(8'h6A, 8'h55);
    rd(8'h6A, 8'h55);
    rd(8'h6E, 8'h00);
    wr(8'h4C, 8'h00);
    rd(8'h6A, 8'h00);
    wr(8'h6B, 8'h01);
    wr(8'h4C, 8'h02);
    wr(8'h6C, 8'h60);
    foreach (drows[i])
    begin
      @(posedge sys_clk_i);
      i2c_req_i <= drows[i].req;
      @(posedge sys_clk_i);
      i2c_req_i <= '0;
      #1 chk(16'(route_o), 16'(drows[i].rt));
      chk(16'(remote_addr_o), 16'(drows[i].ra));
    end
    short_line_i <= 4'h4;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h6D, 8'h78 | 8'(m));
      rd(8'h6D, 8'h78 | 8'(m));
      #1 chk(16'(drop_line_o[2]), 16'(m != 0));
      pk(2, 21'h10_0000, m != 0);
    end
    wr(8'h6D, 8'h71);
    #1 chk(16'(drop_line_o[2]), 16'h0000);
    wr(8'h4C, 8'h00);
    foreach (prows[i])
    begin
      wr(8'h6D, prows[i].cfg);
      pk(0, prows[i].pkt, prows[i].pass);
    end
    rstn_i <= 1'b0;
    strap_i <= 3'h7;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    wr(8'h4C, 8'h03);
    rd(8'h6D, 8'h7F);
    rd(8'h6C, 8'h00);
    end_of_test();
  end
endmodule
bind rxcfg_bank rxcfg_props u_props (.*);
